// ---- include/tsa_consts.svh ----
`ifndef TSA_CONSTS_SVH
`define TSA_CONSTS_SVH

// Model register offsets.
`define TSA_ADDR_COUNT        8'h10
`define TSA_ADDR_OFFSET       8'h3B

// Logical processors served and the width of their index.
`define TSA_NUM_LP            2
`define TSA_LP_W              1

// Reset values.
`define TSA_COUNT_RESET       64'h0000_0000_0000_0000
`define TSA_OFFSET_RESET      64'h0000_0000_0000_0000
`define TSA_RDATA_RESET       64'h0000_0000_0000_0000

// Feature query leaf 07H subleaf 0, EBX bit that reports the offset register.
`define TSA_FEAT_OFFSET_BIT   1
`define TSA_FEAT_OFFSET_VAL   1'h1

// Remainder accumulator width for the ratio scaler.
`define TSA_REM_W             34

`endif

// ---- include/tsa_pkg.sv ----
package tsa_pkg;

	// One 64-bit count word.
	typedef logic [63:0] tsa_word_t;

	// How the count advances.
	typedef enum logic {
		TSA_MODE_CORE,
		TSA_MODE_INVARIANT
	} tsa_mode_t;

endpackage : tsa_pkg

// ---- sim/tsa_timestamp_offset_adjust_test.sv ----
`timescale 1ns/1ns
`include "tsa_consts.svh"

// Self-checking bench for the count and offset register pair.
module tsa_timestamp_offset_adjust_test
	import tsa_pkg::*;
;
	logic        clk, rst_b, xtal, tbr, crf, wr, rd, lp, rvalid, sup, minv;
	logic [31:0] num, den;
	logic [7:0]  addr, ra;
	tsa_word_t   wd, rdata, r1;
	tsa_word_t   base [2];
	tsa_word_t   off [2];
	int          bc [2];
	int          bad_count, total_checks, cyc, seed, i, l;
	bit          inv;

	tsa_timestamp_offset_adjust i_tsa_timestamp_offset_adjust (
		.CLOCK_IN(clk), .RST_B_IN(rst_b), .XTAL_TICK_IN(xtal),
		.TB_RESET_IN(tbr), .CONSTANT_RATE_FLAG_IN(crf),
		.RATIO_NUM_IN(num), .RATIO_DEN_IN(den),
		.MODEL_REGISTER_WRITE_IN(wr), .MODEL_REGISTER_READ_IN(rd),
		.LP_SEL_IN(lp), .ADDR_IN(addr), .WDATA_IN(wd),
		.RDATA_OUT(rdata), .RVALID_OUT(rvalid),
		.OFFSET_SUPPORT_FLAG_OUT(sup), .MODE_INVARIANT_OUT(minv)
	);

	////////////////////////////////////////////////////////////////////////
	// Free-running core clock, 4 ns period.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Edge index and hang guard; a stuck run lands in the same verdict.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	task automatic check(string n, tsa_word_t s, tsa_word_t x);
		total_checks++;
		if (s !== x) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask : check

	// Core-mode count as registered after edge e.
	function automatic tsa_word_t cnt_at(int k, int e);
		return base[k] + tsa_word_t'(e - bc[k]);
	endfunction : cnt_at

	// Expected read data; unmapped places answer zero.
	function automatic tsa_word_t exp_rd(int k, logic [7:0] a, int e);
		if (a == `TSA_ADDR_COUNT) return cnt_at(k, e - 1);
		if (a == `TSA_ADDR_OFFSET) return off[k];
		return 64'h0;
	endfunction : exp_rd

	// One register cycle; the model moves with every accepted write.
	task automatic op(logic r, logic w, int k, logic [7:0] a, tsa_word_t d);
		int e;
		@(negedge clk);
		rd = r;
		wr = w;
		lp = k[0];
		addr = a;
		wd = d;
		@(posedge clk);
		e = cyc;
		#1;
		check("rvalid", rvalid, r);
		if (r && !(inv && a == `TSA_ADDR_COUNT))
			check("rdata", rdata, exp_rd(k, a, e));
		if (w && a == `TSA_ADDR_COUNT) begin
			off[k] += d - cnt_at(k, e - 1);
			base[k] = d;
			bc[k] = e;
		end
		if (w && a == `TSA_ADDR_OFFSET) begin
			base[k] = cnt_at(k, e) + d - off[k];
			bc[k] = e;
			off[k] = d;
		end
	endtask : op

	// Crystal steps, 10 cycles high and 10 low, strobes released.
	task automatic xtal_steps(int n);
		@(negedge clk);
		rd = 1'b0;
		wr = 1'b0;
		repeat (n) begin
			xtal = 1'b1;
			repeat (10) @(negedge clk);
			xtal = 1'b0;
			repeat (10) @(negedge clk);
		end
	endtask : xtal_steps

	////////////////////////////////////////////////////////////////////////
	// Main sequence; the invariant phase goes last since its count
	// cannot be re-based exactly afterwards.
	initial begin
		{xtal, tbr, crf, wr, rd, lp, inv} = '0;
		{bad_count, total_checks, cyc} = '0;
		seed = 32'hB401;
		num = 32'h0;
		den = 32'h1;
		addr = 8'h0;
		wd = 64'h0;
		off = '{64'h0, 64'h0};
		base = '{64'h0, 64'h0};
		rst_b = 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk) rst_b = 1'b1;
		@(posedge clk);
		bc = '{cyc - 1, cyc - 1};
		#1;
		check("support", sup, 1);
		check("mode", minv, 0);
		$display("test reset done");
		op(1, 0, 0, `TSA_ADDR_OFFSET, 0);
		op(1, 0, 1, `TSA_ADDR_OFFSET, 0);
		op(0, 1, 0, `TSA_ADDR_COUNT, 64'hFFFF_FFFF_FFFF_FFFF);
		op(1, 0, 0, `TSA_ADDR_OFFSET, 0);
		op(1, 0, 0, `TSA_ADDR_COUNT, 0);
		op(1, 0, 1, `TSA_ADDR_COUNT, 0);
		op(0, 1, 0, `TSA_ADDR_OFFSET, 64'h8000_0000_0000_0001);
		op(0, 1, 1, `TSA_ADDR_OFFSET, 64'h8000_0000_0000_0001);
		op(1, 0, 1, `TSA_ADDR_COUNT, 0);
		op(0, 1, 0, 8'h11, 64'h1234_5678_9ABC_DEF0);
		op(1, 0, 0, 8'h11, 0);
		for (i = 0; i < 20; i++) op(0, 0, 0, 8'h0, 0);
		op(1, 0, 0, `TSA_ADDR_OFFSET, 0);
		$display("test corners done");
		for (i = 0; i < 60; i++) begin
			l = $random(seed) & 1;
			case ({$random(seed)} % 5)
				0: ra = `TSA_ADDR_COUNT;
				1, 2: ra = `TSA_ADDR_OFFSET;
				3: ra = `TSA_ADDR_COUNT;
				default: ra = $random(seed);
			endcase
			op($random(seed), $random(seed), l, ra,
				{$random(seed), $random(seed)});
		end
		$display("test random done");
		@(negedge clk);
		rd = 1'b0;
		wr = 1'b0;
		crf = 1'b1;
		den = 32'h1 + ({$random(seed)} % 3);
		repeat (3) @(posedge clk);
		#1;
		check("mode", minv, 0);
		@(negedge clk);
		num = 32'h1 + ({$random(seed)} % 4);
		inv = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		check("mode", minv, 1);
		op(1, 0, 0, `TSA_ADDR_COUNT, 0);
		r1 = rdata;
		xtal_steps(5);
		op(1, 0, 0, `TSA_ADDR_COUNT, 0);
		check("scaled", rdata - r1, 64'((num * 5) / den));
		op(1, 0, 0, `TSA_ADDR_OFFSET, 0);
		@(negedge clk);
		rd = 1'b0;
		tbr = 1'b1;
		repeat (6) @(negedge clk);
		tbr = 1'b0;
		repeat (4) @(negedge clk);
		off = '{64'h0, 64'h0};
		for (i = 0; i < 2; i++) begin
			op(1, 0, i, `TSA_ADDR_COUNT, 0);
			check("cleared", rdata, 64'h0);
			op(1, 0, i, `TSA_ADDR_OFFSET, 0);
		end
		$display("test invariant done");
		final_report();
	end

endmodule : tsa_timestamp_offset_adjust_test

// ---- src/tsa_lp_counter.sv ----
`timescale 1ns/1ns
`include "tsa_consts.svh"

// Count and offset register pair for one logical processor.
module tsa_lp_counter
	import tsa_pkg::*;
(
	input  wire logic      clk_in,
	input  wire logic      rst_b_in,
	input  wire logic      tb_clear_in,
	input  wire logic      tick_in,
	input  wire logic      wr_count_in,
	input  wire logic      wr_offset_in,
	input  wire tsa_word_t wdata_in,
	output tsa_word_t      count_out,
	output tsa_word_t      offset_out
);

	tsa_word_t count_r;
	tsa_word_t offset_r;
	tsa_word_t count_diff;
	tsa_word_t offset_diff;

	// Differences wrap modulo 2**64, so a backwards write is a negative step.
	assign count_diff  = wdata_in - count_r;
	assign offset_diff = wdata_in - offset_r;

	assign count_out  = count_r;
	assign offset_out = offset_r;

	////////////////////////////////////////////////////////////////////////
	// The count keeps running during an offset write so no tick is lost.
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			count_r <= `TSA_COUNT_RESET;
		end else if (tb_clear_in) begin
			count_r <= `TSA_COUNT_RESET;
		end else if (wr_count_in) begin
			count_r <= wdata_in;
		end else if (wr_offset_in) begin
			count_r <= count_r + offset_diff + 64'(tick_in);
		end else if (tick_in) begin
			count_r <= count_r + 64'h1;
		end
	end

	// The offset moves only on writes and timebase clears, never with time.
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			offset_r <= `TSA_OFFSET_RESET;
		end else if (tb_clear_in) begin
			offset_r <= `TSA_OFFSET_RESET;
		end else if (wr_offset_in) begin
			offset_r <= wdata_in;
		end else if (wr_count_in) begin
			offset_r <= offset_r + count_diff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on the register pair.
	AST_OFFSET_RESET_ZERO: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		$rose(rst_b_in) |-> offset_r == 64'h0)
		else $error("offset not zero after reset");

	AST_COUNT_WRITE_MOVES_OFFSET: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		wr_count_in && !tb_clear_in |=>
		offset_r == $past(offset_r) + ($past(wdata_in) - $past(count_r)))
		else $error("count write did not move offset by difference");

	AST_OFFSET_WRITE_MOVES_COUNT: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		wr_offset_in && !wr_count_in && !tb_clear_in |=>
		count_r - $past(count_r) ==
		offset_r - $past(offset_r) + 64'($past(tick_in)))
		else $error("offset write did not move count by difference");

	AST_OFFSET_HOLDS: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(!wr_count_in && !wr_offset_in && !tb_clear_in) [*2]
		|-> $stable(offset_r))
		else $error("offset changed without a write");

	AST_COUNT_ONLY_OWN_CAUSE: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		!wr_count_in && !wr_offset_in && !tb_clear_in && !tick_in
		|=> $stable(count_r))
		else $error("count changed with no cause");

	AST_TIMEBASE_CLEAR: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		tb_clear_in |=> count_r == 64'h0 && offset_r == 64'h0)
		else $error("timebase clear left count or offset");

	AST_WRAP_SUM: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		wr_count_in && !tb_clear_in |=>
		offset_r - count_r == $past(offset_r) - $past(count_r))
		else $error("count write broke the count to offset link");

	COV_COUNT_WRITE: cover property (
		@(posedge clk_in) disable iff (!rst_b_in)
		wr_count_in && wdata_in < count_r);
	COV_OFFSET_WRITE: cover property (
		@(posedge clk_in) disable iff (!rst_b_in) wr_offset_in);

endmodule : tsa_lp_counter

// ---- src/tsa_timestamp_offset_adjust.sv ----
`timescale 1ns/1ns
`include "tsa_consts.svh"

// What this block does
// - Reset clears every logical processor's offset register to zero.
// - A count write adds the new minus old count to the offset.
// - An offset write adds the new minus old offset to the count.
// - The offset changes only on writes and timebase resets, never as time passes.
// - Each logical processor has its own 64-bit offset at address 3BH.
// - A count write touches only the writing processor's count.
// - Feature leaf 07H EBX bit 1 reports the offset register.
// - The always-running timebase follows the crystal, not the core clock.
// - Invariant mode scales timebase by numerator over denominator plus offset.
// - A timebase reset clears the invariant count and its offset.
module tsa_timestamp_offset_adjust
	import tsa_pkg::*;
(
	input  wire logic                  CLOCK_IN,
	input  wire logic                  RST_B_IN,
	input  wire logic                  XTAL_TICK_IN,
	input  wire logic                  TB_RESET_IN,
	input  wire logic                  CONSTANT_RATE_FLAG_IN,
	input  wire logic [31:0]           RATIO_NUM_IN,
	input  wire logic [31:0]           RATIO_DEN_IN,
	input  wire logic                  MODEL_REGISTER_WRITE_IN,
	input  wire logic                  MODEL_REGISTER_READ_IN,
	input  wire logic [`TSA_LP_W-1:0]  LP_SEL_IN,
	input  wire logic [7:0]            ADDR_IN,
	input  wire tsa_word_t             WDATA_IN,
	output tsa_word_t                  RDATA_OUT,
	output logic                       RVALID_OUT,
	output logic                       OFFSET_SUPPORT_FLAG_OUT,
	output logic                       MODE_INVARIANT_OUT
);

	logic [2:0]            xtal_sync_r;
	logic [1:0]            tbrst_sync_r;
	logic                  xtal_edge;
	tsa_mode_t             mode;
	logic [`TSA_REM_W-1:0] rem_r;
	logic [`TSA_REM_W-1:0] rem_nxt;
	logic                  drain;
	logic                  tick;
	logic                  tb_clear;
	tsa_word_t             count_w  [`TSA_NUM_LP];
	tsa_word_t             offset_w [`TSA_NUM_LP];
	tsa_word_t             rdata_r;
	logic                  rvalid_r;
	logic                  feat_r;
	logic                  mode_r;

	////////////////////////////////////////////////////////////////////////
	// Crystal tick and timebase reset arrive from pins, so two flops first;
	// the third crystal flop only serves the edge detector.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_B_IN) begin
			xtal_sync_r <= 3'h0;
		end else begin
			xtal_sync_r <= {xtal_sync_r[1:0], XTAL_TICK_IN};
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_B_IN) begin
			tbrst_sync_r <= 2'h0;
		end else begin
			tbrst_sync_r <= {tbrst_sync_r[0], TB_RESET_IN};
		end
	end

	// One timebase step per crystal rising edge, whatever the core rate.
	assign xtal_edge = xtal_sync_r[1] & ~xtal_sync_r[2];

	////////////////////////////////////////////////////////////////////////
	// Mode and scaler. A zero numerator falls back to core counting.
	assign mode = (CONSTANT_RATE_FLAG_IN && RATIO_NUM_IN != 32'h0) ?
		TSA_MODE_INVARIANT : TSA_MODE_CORE;
	assign tb_clear = tbrst_sync_r[1] && mode == TSA_MODE_INVARIANT;

	// The remainder gains the numerator per timebase step and sheds one
	// denominator per count step. Draining one step a clock is enough as
	// long as the crystal is much slower than the core.
	assign drain = RATIO_DEN_IN != 32'h0 &&
		rem_r >= {2'h0, RATIO_DEN_IN};

	always_comb begin
		rem_nxt = rem_r;
		if (xtal_edge) begin
			rem_nxt = rem_nxt + {2'h0, RATIO_NUM_IN};
		end
		if (drain) begin
			rem_nxt = rem_nxt - {2'h0, RATIO_DEN_IN};
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_B_IN) begin
			rem_r <= {`TSA_REM_W{1'b0}};
		end else if (tb_clear || mode != TSA_MODE_INVARIANT) begin
			rem_r <= {`TSA_REM_W{1'b0}};
		end else begin
			rem_r <= rem_nxt;
		end
	end

	assign tick = mode == TSA_MODE_INVARIANT ? drain : 1'b1;

	////////////////////////////////////////////////////////////////////////
	// One register pair per logical processor; writes go only to the
	// selected one. Software keeps them aligned through equal offsets.
	for (genvar i = 0; i < `TSA_NUM_LP; i++) begin : g_lp
		logic sel;
		assign sel = MODEL_REGISTER_WRITE_IN &&
			LP_SEL_IN == (`TSA_LP_W)'(i);
		tsa_lp_counter u_lp (
			.clk_in       (CLOCK_IN),
			.rst_b_in     (RST_B_IN),
			.tb_clear_in  (tb_clear),
			.tick_in      (tick),
			.wr_count_in  (sel && ADDR_IN == `TSA_ADDR_COUNT),
			.wr_offset_in (sel && ADDR_IN == `TSA_ADDR_OFFSET),
			.wdata_in     (WDATA_IN),
			.count_out    (count_w[i]),
			.offset_out   (offset_w[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Read port: data one clock after the request. Unknown addresses and
	// out-of-range processors read as zero rather than faulting.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_B_IN) begin
			rdata_r <= `TSA_RDATA_RESET;
		end else if (MODEL_REGISTER_READ_IN) begin
			if (32'(LP_SEL_IN) >= `TSA_NUM_LP) begin
				rdata_r <= `TSA_RDATA_RESET;
			end else if (ADDR_IN == `TSA_ADDR_COUNT) begin
				rdata_r <= count_w[LP_SEL_IN];
			end else if (ADDR_IN == `TSA_ADDR_OFFSET) begin
				rdata_r <= offset_w[LP_SEL_IN];
			end else begin
				rdata_r <= `TSA_RDATA_RESET;
			end
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_B_IN) begin
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= MODEL_REGISTER_READ_IN;
		end
	end

	// Feature and mode status flops.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_B_IN) begin
			feat_r <= 1'b0;
			mode_r <= 1'b0;
		end else begin
			feat_r <= `TSA_FEAT_OFFSET_VAL;
			mode_r <= mode == TSA_MODE_INVARIANT;
		end
	end

	assign RDATA_OUT               = rdata_r;
	assign RVALID_OUT              = rvalid_r;
	assign OFFSET_SUPPORT_FLAG_OUT = feat_r;
	assign MODE_INVARIANT_OUT      = mode_r;

	////////////////////////////////////////////////////////////////////////
	// Checks on scaling, reads, write isolation and feature reporting.
	AST_FEATURE_SET: assert property (
		@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		$past(RST_B_IN) |-> OFFSET_SUPPORT_FLAG_OUT)
		else $error("offset support flag not reported");

	AST_TB_STEP_ADDS_NUM: assert property (
		@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		mode == TSA_MODE_INVARIANT && xtal_edge && !drain && !tb_clear
		&& $stable(mode) |=> mode != TSA_MODE_INVARIANT ||
		rem_r == $past(rem_r) + {2'h0, $past(RATIO_NUM_IN)})
		else $error("timebase step did not add numerator");

	AST_INVARIANT_TICK: assert property (
		@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		mode == TSA_MODE_INVARIANT && drain && !xtal_edge && !tb_clear
		|=> rem_r == $past(rem_r) - {2'h0, $past(RATIO_DEN_IN)})
		else $error("count step did not take one denominator");

	AST_OFFSET_READBACK: assert property (
		@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		MODEL_REGISTER_READ_IN && ADDR_IN == `TSA_ADDR_OFFSET &&
		LP_SEL_IN == 1'h0 |=> RVALID_OUT && RDATA_OUT == $past(offset_w[0]))
		else $error("offset read returned wrong data");

	AST_OTHER_LP_UNTOUCHED: assert property (
		@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		MODEL_REGISTER_WRITE_IN && LP_SEL_IN == 1'h0 && !tb_clear |=>
		$stable(offset_w[1]))
		else $error("write leaked into another processor");

	COV_INVARIANT_TICK: cover property (
		@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		mode == TSA_MODE_INVARIANT && drain);
	COV_TB_CLEAR: cover property (
		@(posedge CLOCK_IN) disable iff (!RST_B_IN) tb_clear);
	COV_READ: cover property (
		@(posedge CLOCK_IN) disable iff (!RST_B_IN) RVALID_OUT);

endmodule : tsa_timestamp_offset_adjust
